// ---- fault_check_pkg.sv ----
// Purpose: constants and types for the reserved-bit fault checker
// Assumes: one instruction presented per cycle by the core front end
// Notes: feature masks are parameters of the top; defaults are arbitrary
// Behaviour
// RULE1: reserved feature-control bit change raises protection fault
// RULE2: older core faults every feature-control access
// RULE3: unsupported instruction encoding raises invalid-opcode fault
// RULE4: setting unimplemented flag or control bit faults
// RULE5: older core writes model registers unchecked
// RULE6: newer functions enabled only by set control flags
// RULE7: identify instruction reports present features
// RULE8: software masks reserved bits before testing
// RULE9: software writes reserved bits with documented values
// RULE10: one fault per instruction, no state update
package fault_check_pkg;
   localparam int unsigned reg_w = 32;
   localparam logic [31:0] feature_control_reset = 32'h0000_0000;
   localparam logic [31:0] flags_word_reset      = 32'h0000_0002;
   localparam logic [31:0] model_reg_reset       = 32'h0000_0000;
   localparam logic [31:0] flags_fixed_one       = 32'h0000_0002;

   typedef enum logic [2:0] {
      op_none,
      op_write_feature_control,
      op_read_feature_control,
      op_write_flags,
      op_write_model_reg,
      op_identify,
      op_other
   } op_t;

   typedef enum logic [1:0] {
      fault_none,
      fault_general_protection,
      fault_invalid_opcode
   } fault_t;
endpackage

// ---- fault_check_props.sv ----
// Purpose: port assertions for the reserved-bit fault checker
// Assumes: one op per cycle, answer one cycle later
// Notes: bound to every instance, older or newer
`timescale 1ns/1ns
module fault_props
#(
   parameter logic        older_core       = 1'b0,
   parameter logic [31:0] fc_implemented   = 32'h0000_00ff,
   parameter logic [31:0] feature_present  = 32'h0000_1234,
   parameter logic [31:0] opcode_supported = 32'h0000_00ff
)
(
   input wire logic                    clk_sys,
   input wire logic                    rstn,
   input wire logic                    op_valid,
   input wire fault_check_pkg::op_t    op,
   input wire logic [31:0]             op_data,
   input wire logic [4:0]              op_class,
   input wire logic                    done,
   input wire fault_check_pkg::fault_t fault,
   input wire logic [31:0]             result,
   input wire logic [31:0]             feature_control_reg,
   input wire logic [31:0]             flags_word,
   input wire logic [31:0]             model_reg,
   input wire logic [7:0]              function_enable
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic wr_fc;
   logic rsv_fc;
   assign wr_fc = op_valid && op == fault_check_pkg::op_write_feature_control;
   assign rsv_fc = ((op_data ^ feature_control_reg) & ~fc_implemented) != 32'h0;
   a_done_follows: assert property (op_valid |=> done)
      else $error("no done after op");
   a_done_cause: assert property (done |-> $past(op_valid))
      else $error("done without op");
   a_fault_quiet: assert property (!done |-> fault == fault_check_pkg::fault_none)
      else $error("fault outside done");
   a_fc_reserved_prot: assert property (!older_core && wr_fc && rsv_fc |=>
      fault == fault_check_pkg::fault_general_protection) else $error("reserved change missed");
   a_fc_commit: assert property (!older_core && wr_fc && !rsv_fc |=>
      feature_control_reg == $past(op_data)) else $error("control write lost");
   a_fault_no_update: assert property (done && fault != fault_check_pkg::fault_none |->
      $stable(feature_control_reg) && $stable(flags_word) && $stable(model_reg))
      else $error("state moved on fault");
   a_old_fc_refused: assert property (older_core && op_valid &&
      (wr_fc || op == fault_check_pkg::op_read_feature_control) |=>
      fault == fault_check_pkg::fault_invalid_opcode) else $error("older access not refused");
   a_class_refused: assert property (op_valid && op == fault_check_pkg::op_other &&
      !opcode_supported[op_class] |=> fault == fault_check_pkg::fault_invalid_opcode)
      else $error("unsupported op accepted");
   a_enable_gate: assert property (!$stable(function_enable) |-> $past(wr_fc))
      else $error("enable moved without control write");
   a_identify_data: assert property (!older_core && op_valid &&
      op == fault_check_pkg::op_identify |=> result == feature_present)
      else $error("identify data wrong");
   cover property (wr_fc && rsv_fc ##1 done);
   cover property (op_valid && op == fault_check_pkg::op_identify);
   cover property (done && fault == fault_check_pkg::fault_invalid_opcode);
endmodule
bind reserved_bit_fault_check fault_props #(.older_core(older_core),
   .fc_implemented(fc_implemented), .feature_present(feature_present),
   .opcode_supported(opcode_supported)) props (.clk_sys, .rstn, .op_valid, .op, .op_data,
   .op_class, .done, .fault, .result, .feature_control_reg, .flags_word, .model_reg,
   .function_enable);

// ---- fault_priority.sv ----
// Purpose: pick exactly one fault for an instruction
// Assumes: invalid-opcode outranks general-protection
// Notes: purely combinational
`timescale 1ns/1ns
module fault_priority
(
   input  wire logic                    want_opcode_fault,
   input  wire logic                    want_prot_fault,
   output      fault_check_pkg::fault_t fault,
   output      logic                    commit_ok
);
   always_comb
   begin
      if (want_opcode_fault)
         fault = fault_check_pkg::fault_invalid_opcode; // RULE10
      else if (want_prot_fault)
         fault = fault_check_pkg::fault_general_protection; // RULE10
      else
         fault = fault_check_pkg::fault_none;
      commit_ok = !want_opcode_fault && !want_prot_fault; // RULE10
   end
endmodule

// ---- reserved_bit_fault_check.sv ----
// Purpose: fault checks on control state writes and instruction support
// Assumes: op_valid marks a one-cycle instruction presentation
// Notes: results registered one cycle after op_valid
`timescale 1ns/1ns
module reserved_bit_fault_check
#(
   parameter logic        older_core        = 1'b0,
   parameter logic [31:0] fc_implemented    = 32'h0000_00ff,
   parameter logic [31:0] flags_implemented = 32'h003f_7fd5,
   parameter logic [31:0] model_implemented = 32'h0000_000f,
   parameter logic [31:0] feature_present   = 32'h0000_1234, // arbitrary
   parameter logic [31:0] opcode_supported  = 32'h0000_00ff
)
(
   input  wire logic                    clk_sys,
   input  wire logic                    rstn,
   input  wire logic                    op_valid,
   input  wire fault_check_pkg::op_t    op,
   input  wire logic [31:0]             op_data,
   input  wire logic [4:0]              op_class,
   output      logic                    done,
   output      fault_check_pkg::fault_t fault,
   output      logic [31:0]             result,
   output      logic [31:0]             feature_control_reg,
   output      logic [31:0]             flags_word,
   output      logic [31:0]             model_reg,
   output      logic [7:0]              function_enable
);
   // decoded instruction kinds, at most one high per cycle
   logic                    fc_write;
   logic                    fc_read;
   logic                    flags_write;
   logic                    model_write;
   logic                    ident_op;
   logic                    other_op;
   logic                    code_illegal;

   // refusal causes, weighed against each other by the priority picker
   logic                    fc_absent;
   logic                    ident_absent;
   logic                    class_absent;
   logic                    fc_reserved_hit;
   logic                    flags_reserved_hit;
   logic                    model_reserved_hit;
   logic                    want_opcode_fault;
   logic                    want_prot_fault;
   logic                    commit_ok;
   fault_check_pkg::fault_t pick;

   // next values, one set per state group
   logic                    next_done;
   fault_check_pkg::fault_t next_fault;
   logic [31:0]             next_result;
   logic [31:0]             next_fc;
   logic [7:0]              next_enable;
   logic [31:0]             next_flags;
   logic [31:0]             next_model;

   // reserved bits may only be rewritten with the value they already hold
   function automatic logic touches_reserved(input logic [31:0] val,
                                             input logic [31:0] cur,
                                             input logic [31:0] impl);
      touches_reserved = |((val ^ cur) & ~impl);
   endfunction

   always_comb
   begin
      fc_write     = 1'b0;
      fc_read      = 1'b0;
      flags_write  = 1'b0;
      model_write  = 1'b0;
      ident_op     = 1'b0;
      other_op     = 1'b0;
      code_illegal = 1'b0;
      if (op_valid)
      begin
         unique case (op)
            // a bubble is answered with done but changes nothing
            fault_check_pkg::op_none:
               code_illegal = 1'b0;
            fault_check_pkg::op_write_feature_control:
               fc_write = 1'b1;
            fault_check_pkg::op_read_feature_control:
               fc_read = 1'b1;
            fault_check_pkg::op_write_flags:
               flags_write = 1'b1;
            fault_check_pkg::op_write_model_reg:
               model_write = 1'b1;
            fault_check_pkg::op_identify:
               ident_op = 1'b1;
            fault_check_pkg::op_other:
               other_op = 1'b1;
            // spare code: an encoding this core never implemented
            default:
               code_illegal = 1'b1; // RULE3
         endcase
      end
   end

   // all causes are computed side by side; only the picker orders them
   assign fc_absent          = older_core && (fc_write || fc_read); // RULE2
   assign ident_absent       = older_core && ident_op; // RULE3
   assign class_absent       = other_op && !opcode_supported[op_class]; // RULE3
   assign fc_reserved_hit    = fc_write && touches_reserved(op_data, feature_control_reg,
                                                            fc_implemented); // RULE1
   assign flags_reserved_hit = flags_write && touches_reserved(op_data, flags_word,
                                                               flags_implemented); // RULE4
   // older cores store model bits unchecked; newer ones refuse reserved changes
   assign model_reserved_hit = model_write && !older_core &&
                               touches_reserved(op_data, model_reg, model_implemented); // RULE5
   assign want_opcode_fault  = fc_absent ||
                               ident_absent ||
                               class_absent ||
                               code_illegal;
   assign want_prot_fault    = fc_reserved_hit ||
                               flags_reserved_hit ||
                               model_reserved_hit;

   // opcode refusal outranks protection, so an older core reports only one
   fault_priority u_prio
   (
      .want_opcode_fault (want_opcode_fault),
      .want_prot_fault   (want_prot_fault),
      .fault             (pick),
      .commit_ok         (commit_ok)
   );

   // response group: the answer stands one cycle, zero when nothing was taken
   always_comb
   begin
      next_done   = op_valid;
      next_fault  = fault_check_pkg::fault_none;
      next_result = 32'h0000_0000;
      if (op_valid)
      begin
         next_fault = pick; // RULE10
         if (commit_ok && fc_read)
            next_result = feature_control_reg;
         else if (commit_ok && ident_op)
            next_result = feature_present; // RULE7
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         done   <= 1'b0;
         fault  <= fault_check_pkg::fault_none;
         result <= 32'h0000_0000;
      end
      else
      begin
         done   <= next_done;
         fault  <= next_fault;
         result <= next_result;
      end
   end

   // control group: enables registered from the committed value, so they never lag it
   always_comb
   begin
      next_fc = feature_control_reg;
      if (fc_write && commit_ok) // RULE10
         next_fc = op_data;
      next_enable = next_fc[7:0] & fc_implemented[7:0]; // RULE6
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         feature_control_reg <= fault_check_pkg::feature_control_reset;
         // reset clears every flag, so all new functions start off
         function_enable     <= fault_check_pkg::feature_control_reset[7:0] & fc_implemented[7:0];
      end
      else
      begin
         feature_control_reg <= next_fc;
         function_enable     <= next_enable;
      end
   end

   // flags group: the fixed-one bit is forced so software cannot clear it
   always_comb
   begin
      next_flags = flags_word;
      if (flags_write && commit_ok) // RULE10
         next_flags = op_data | fault_check_pkg::flags_fixed_one;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         flags_word <= fault_check_pkg::flags_word_reset;
      end
      else
      begin
         flags_word <= next_flags;
      end
   end

   // model group: unchecked bits still stored; software must not rely on them
   always_comb
   begin
      next_model = model_reg;
      if (model_write && commit_ok) // RULE10
         next_model = op_data; // RULE5
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         model_reg <= fault_check_pkg::model_reg_reset;
      end
      else
      begin
         model_reg <= next_model;
      end
   end
endmodule

// ---- test_reserved_bit_fault_check.sv ----
// Purpose: directed bench for the reserved-bit fault checker
// Assumes: newer and older core instances share one stimulus
// Notes: op and fault codes given as raw enum encodings to keep calls short
`timescale 1ns/1ns
module test_reserved_bit_fault_check;
   logic                    clk_sys = 1'b0;
   logic                    rstn = 1'b0;
   logic                    op_valid = 1'b0;
   fault_check_pkg::op_t    op = fault_check_pkg::op_none;
   logic [31:0]             op_data = 32'h0;
   logic [4:0]              op_class = 5'h0;
   logic                    done;
   fault_check_pkg::fault_t fault, o_fault;
   logic [31:0]             result, fc, flags, model, o_model;
   logic [7:0]              fen;
   int                      n_fail = 0;
   int                      check_count = 0;
   int                      cyc = 0;
   initial forever #20 clk_sys = ~clk_sys;
   reserved_bit_fault_check dut (.clk_sys, .rstn, .op_valid, .op, .op_data, .op_class, .done,
      .fault, .result, .feature_control_reg(fc), .flags_word(flags), .model_reg(model),
      .function_enable(fen));
   reserved_bit_fault_check #(.older_core(1'b1)) old (.clk_sys, .rstn, .op_valid, .op,
      .op_data, .op_class, .done(), .fault(o_fault), .result(), .feature_control_reg(),
      .flags_word(), .model_reg(o_model), .function_enable());
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         n_fail++;
      end
   endtask
   task automatic test_done();
      if (n_fail == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // one op, answer judged on both cores one edge later
   task automatic run(input logic [2:0] o, input logic [31:0] d, input logic [4:0] c,
      input logic [1:0] ef, input logic [1:0] eo);
      @(posedge clk_sys);
      #1;
      op = fault_check_pkg::op_t'(o);
      op_data = d;
      op_class = c;
      op_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      op_valid = 1'b0;
      chk(done, 32'h1);
      chk(fault, ef);
      chk(o_fault, eo);
   endtask
   task automatic t_feature();
      chk(fen, 32'h0);
      run(3'h1, 32'h5, 5'h0, 2'h0, 2'h2);
      chk(fen, 32'h5);
      run(3'h1, 32'h105, 5'h0, 2'h1, 2'h2);
      chk(fc, 32'h5);
      run(3'h2, 32'h0, 5'h0, 2'h0, 2'h2);
      chk(result, 32'h5);
      chk(result & 32'h0000_00ff, 32'h5);
   endtask
   task automatic t_flags();
      run(3'h3, 32'h3, 5'h0, 2'h0, 2'h0);
      run(3'h3, 32'hb, 5'h0, 2'h1, 2'h1);
      chk(flags, 32'h3);
   endtask
   task automatic t_model();
      run(3'h4, 32'h13, 5'h0, 2'h1, 2'h0);
      chk(model, 32'h0);
      chk(o_model, 32'h13);
   endtask
   task automatic t_ident();
      run(3'h5, 32'h0, 5'h0, 2'h0, 2'h2);
      chk(result, 32'h1234);
      run(3'h6, 32'h0, 5'h3, 2'h0, 2'h0);
      run(3'h6, 32'h0, 5'h9, 2'h2, 2'h2);
      run(3'h7, 32'h0, 5'h0, 2'h2, 2'h2);
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_fail++;
         test_done();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      t_feature();
      t_flags();
      t_model();
      t_ident();
      test_done();
   end
endmodule
